// >>> shared/svht_pkg.sv
package svht_pkg;
  localparam int SMP_W = 8;
  localparam int NSRC = 5;
  localparam int SRC_W = 3;
  localparam int TIME_W = 16;
  localparam int CNT_W = 16;
  localparam int CTRL_W = 2;
  localparam int STAT_W = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [SRC_W-1:0] SRC_CH1 = 3'h1;
  localparam logic [SRC_W-1:0] SRC_CH2 = 3'h2;
  localparam logic [SRC_W-1:0] SRC_CH4 = 3'h4;
  localparam logic [SRC_W-1:0] SRC_EXT = 3'h5;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLK_SRC = 8'h04;
  localparam logic [7:0] OFF_DATA_SRC = 8'h08;
  localparam logic [7:0] OFF_SETUP = 8'h0C;
  localparam logic [7:0] OFF_HOLD = 8'h10;
  localparam logic [7:0] OFF_HTHR = 8'h14;
  localparam logic [7:0] OFF_LTHR = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_MASK = 8'h20;
  localparam logic [7:0] OFF_LVL_BASE = 8'h40;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_EDGE_BIT = 1;
  localparam int STAT_SETUP = 0;
  localparam int STAT_HOLD = 1;
  localparam int STAT_CMDERR = 2;
  localparam int LVL_SRC_LSB = 8;
  localparam logic [TIME_W-1:0] SETUP_RST = 16'h0014;
  localparam logic [TIME_W-1:0] HOLD_RST = 16'h0014;
  localparam logic [SMP_W-1:0] HTHR_RST = 8'hA0;
  localparam logic [SMP_W-1:0] LTHR_RST = 8'h60;
  localparam logic [SMP_W-1:0] LVL_RST = 8'h80;
  typedef enum logic {SVHT_EDGE_RISE = 1'b0, SVHT_EDGE_FALL = 1'b1} svht_edge_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PRIME = 2'b01,
    ST_ARM   = 2'b10,
    ST_HOLD  = 2'b11
  } svht_state_t;
  // least time in ns rounded up to whole clock cycles
  function automatic logic [CNT_W-1:0] ns_to_cyc(input logic [TIME_W-1:0] ns);
    logic [TIME_W:0] sum;
    sum = {1'b0, ns} + (TIME_W+1)'(CLK_PERIOD_NS - 1);
    ns_to_cyc = CNT_W'(sum / (TIME_W+1)'(CLK_PERIOD_NS));
  endfunction
endpackage

// >>> shared/svht_mon_if.sv
`timescale 1ns/1ns
`default_nettype none
interface svht_mon_if;
  import svht_pkg::*;
  logic [SMP_W-1:0] clk_sample;
  logic [SMP_W-1:0] data_sample;
  logic [SMP_W-1:0] clk_level;
  logic [SMP_W-1:0] hi_thr;
  logic [SMP_W-1:0] lo_thr;
  logic             clk_above;
  logic             data_valid;
  logic             data_high;
  modport cmp (
    input  clk_sample, data_sample, clk_level, hi_thr, lo_thr,
    output clk_above, data_valid, data_high
  );
  modport chk (input clk_above, data_valid, data_high);
endinterface
`default_nettype wire

// >>> verilog/svht_level_cmp.sv
`timescale 1ns/1ns
`default_nettype none
module svht_level_cmp
  import svht_pkg::*;
(
  input  wire logic  i_sys_clk, // system clock
  input  wire logic  i_rst_n,   // async reset, active low
  svht_mon_if.cmp    mon        // samples in, levels out
);
  logic above_reg, above_next;
  logic valid_reg, valid_next;
  logic high_reg, high_next;

  always_comb begin
    above_next = mon.clk_sample > mon.clk_level;
    high_next = mon.data_sample > mon.hi_thr;
    valid_next = high_next || (mon.data_sample < mon.lo_thr);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      above_reg <= 1'b0;
      valid_reg <= 1'b0;
      high_reg <= 1'b0;
    end else begin
      above_reg <= above_next;
      valid_reg <= valid_next;
      high_reg <= high_next;
    end
  end

  assign mon.clk_above = above_reg;
  assign mon.data_valid = valid_reg;
  assign mon.data_high = high_reg;

  a_valid_band: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    mon.data_valid |-> $past(mon.data_sample > mon.hi_thr || mon.data_sample < mon.lo_thr))
    else $error("data valid inside threshold band");
endmodule
`default_nettype wire

// >>> verilog/svht_checker.sv
`timescale 1ns/1ns
`default_nettype none
module svht_checker
  import svht_pkg::*;
(
  input  wire logic             i_sys_clk,    // system clock
  input  wire logic             i_rst_n,      // async reset, active low
  svht_mon_if.chk               mon,          // compared clock and data
  input  wire logic             i_en,         // check enable
  input  wire svht_edge_t       i_edge,       // active clock direction
  input  wire logic [CNT_W-1:0] i_setup_cyc,  // setup window, cycles
  input  wire logic [CNT_W-1:0] i_hold_cyc,   // hold window, cycles
  output logic                  o_setup_viol, // setup violation pulse
  output logic                  o_hold_viol,  // hold violation pulse
  output logic                  o_trig        // trigger event pulse
);
  svht_state_t      st_reg, st_next;
  logic             cprev_reg, dprev_reg;
  logic [CNT_W-1:0] stab_reg, stab_next;
  logic [CNT_W-1:0] hcnt_reg, hcnt_next;
  logic             sv_next, hv_next, sv_reg, hv_reg, trig_reg;
  logic             rise, fall, act, changed;

  always_comb begin
    rise = mon.clk_above & ~cprev_reg;
    fall = ~mon.clk_above & cprev_reg;
    act = (i_edge == SVHT_EDGE_RISE) ? rise : fall;
    changed = ~mon.data_valid | (mon.data_high != dprev_reg);
    stab_next = changed ? '0 : ((&stab_reg) ? stab_reg : stab_reg + 1'b1);
    st_next = st_reg;
    hcnt_next = hcnt_reg;
    sv_next = 1'b0;
    hv_next = 1'b0;
    case (st_reg)
      ST_IDLE: if (i_en) st_next = ST_PRIME;
      ST_PRIME: if (rise | fall) st_next = ST_ARM;
      ST_ARM: if (act) begin
        if (stab_reg < i_setup_cyc) begin
          sv_next = 1'b1;
        end else if (i_hold_cyc != '0) begin
          st_next = ST_HOLD;
          hcnt_next = '0;
        end
      end
      ST_HOLD: begin
        if (changed) begin
          hv_next = 1'b1;
          st_next = ST_ARM;
        end else begin
          hcnt_next = hcnt_reg + 1'b1;
          if (hcnt_next >= i_hold_cyc) st_next = ST_ARM;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    if (!i_en) begin
      st_next = ST_IDLE;
      sv_next = 1'b0;
      hv_next = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= ST_IDLE;
      cprev_reg <= 1'b0;
      dprev_reg <= 1'b0;
      stab_reg <= '0;
      hcnt_reg <= '0;
      sv_reg <= 1'b0;
      hv_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cprev_reg <= mon.clk_above;
      dprev_reg <= mon.data_high;
      stab_reg <= stab_next;
      hcnt_reg <= hcnt_next;
      sv_reg <= sv_next;
      hv_reg <= hv_next;
      trig_reg <= sv_next | hv_next;
    end
  end

  assign o_setup_viol = sv_reg;
  assign o_hold_viol = hv_reg;
  assign o_trig = trig_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_setup_short: assert property (
    i_en && st_reg == ST_ARM && act && stab_reg < i_setup_cyc |=> o_setup_viol)
    else $error("short setup not flagged");
  a_hold_break: assert property (
    i_en && st_reg == ST_HOLD && changed |=> o_hold_viol ##1 !o_hold_viol)
    else $error("hold break not flagged");
  a_edge_dir: assert property (
    o_setup_viol |-> $past(i_edge == SVHT_EDGE_RISE ? rise : fall))
    else $error("setup check on wrong edge");
  a_prime_first: assert property (
    st_reg == ST_IDLE ##1 st_reg == ST_PRIME |-> !o_setup_viol [*2])
    else $error("check before first crossing");
endmodule
`default_nettype wire

// >>> verilog/svht_top.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module svht_top
  import svht_pkg::*;
#(
  parameter bit TWO_CH_MODEL = 1'b0
) (
  input  wire logic                  i_sys_clk,   // 100 MHz clock
  input  wire logic                  i_rst_n,     // async reset, active low
  input  wire logic                  i_psel,      // apb select
  input  wire logic                  i_penable,   // apb enable
  input  wire logic                  i_pwrite,    // apb write
  input  wire logic [7:0]            i_paddr,     // apb byte address
  input  wire logic [31:0]           i_pwdata,    // apb write data
  output logic      [31:0]           o_prdata,    // apb read data
  output logic                       o_pready,    // apb ready
  output logic                       o_pslverr,   // apb error
  input  wire logic [NSRC*SMP_W-1:0] i_chan_smp,  // sampled probe codes
  output logic                       o_trig,      // trigger event pulse
  output logic                       o_setup_viol, // setup violation pulse
  output logic                       o_hold_viol, // hold violation pulse
  output logic                       o_irq        // interrupt level
);
  localparam int LVL_IW = 3;

  function automatic logic src_ok(input logic [SRC_W-1:0] c);
    if (c == SRC_EXT) src_ok = TWO_CH_MODEL;
    else src_ok = (c >= SRC_CH1) && (c <= (TWO_CH_MODEL ? SRC_CH2 : SRC_CH4));
  endfunction

  function automatic logic [LVL_IW-1:0] src_idx(input logic [SRC_W-1:0] c);
    src_idx = LVL_IW'(c - SRC_CH1);
  endfunction

  function automatic logic lvl_hit(input logic [7:0] a);
    lvl_hit = (a >= OFF_LVL_BASE) && (a < OFF_LVL_BASE + 8'(4 * NSRC)) && (a[1:0] == 2'h0);
  endfunction

  logic [NSRC*SMP_W-1:0] smp_s1_reg, smp_s2_reg;

  // two-stage synchroniser for the probe sample codes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      smp_s1_reg <= '0;
      smp_s2_reg <= '0;
    end else begin
      smp_s1_reg <= i_chan_smp;
      smp_s2_reg <= smp_s1_reg;
    end
  end

  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [SRC_W-1:0]  csrc_reg, csrc_next;
  logic [SRC_W-1:0]  dsrc_reg, dsrc_next;
  logic [TIME_W-1:0] setup_reg, setup_next;
  logic [TIME_W-1:0] hold_reg, hold_next;
  logic [SMP_W-1:0]  hthr_reg, hthr_next;
  logic [SMP_W-1:0]  lthr_reg, lthr_next;
  logic [SMP_W-1:0]  lvl_reg [NSRC];
  logic [SMP_W-1:0]  lvl_next [NSRC];
  logic [STAT_W-1:0] stat_reg, stat_next;
  logic [STAT_W-1:0] mask_reg, mask_next;
  logic [31:0]       rd_reg, rd_next;
  logic              setup_ph, acc_ph, wr_acc, mapped, bad_src;
  logic [LVL_IW-1:0] lvl_i;
  logic              sv, hv, trig;

  always_comb begin
    setup_ph = i_psel & ~i_penable;
    acc_ph = i_psel & i_penable;
    wr_acc = acc_ph & i_pwrite;
    lvl_i = LVL_IW'((i_paddr - OFF_LVL_BASE) >> 2);
    case (i_paddr)
      OFF_CTRL, OFF_CLK_SRC, OFF_DATA_SRC, OFF_SETUP, OFF_HOLD,
      OFF_HTHR, OFF_LTHR, OFF_STATUS, OFF_MASK: mapped = 1'b1;
      default: mapped = lvl_hit(i_paddr);
    endcase
    bad_src = i_pwrite && (i_paddr == OFF_CLK_SRC || i_paddr == OFF_DATA_SRC)
              && !src_ok(i_pwdata[SRC_W-1:0]);
  end

  // register writes take effect in the access phase
  always_comb begin
    ctrl_next = ctrl_reg;
    csrc_next = csrc_reg;
    dsrc_next = dsrc_reg;
    setup_next = setup_reg;
    hold_next = hold_reg;
    hthr_next = hthr_reg;
    lthr_next = lthr_reg;
    mask_next = mask_reg;
    for (int k = 0; k < NSRC; k++) lvl_next[k] = lvl_reg[k];
    if (wr_acc && !bad_src) begin
      case (i_paddr)
        OFF_CTRL: ctrl_next = i_pwdata[CTRL_W-1:0];
        OFF_CLK_SRC: csrc_next = i_pwdata[SRC_W-1:0];
        OFF_DATA_SRC: dsrc_next = i_pwdata[SRC_W-1:0];
        OFF_SETUP: setup_next = i_pwdata[TIME_W-1:0];
        OFF_HOLD: hold_next = i_pwdata[TIME_W-1:0];
        OFF_HTHR: hthr_next = i_pwdata[SMP_W-1:0];
        OFF_LTHR: lthr_next = i_pwdata[SMP_W-1:0];
        OFF_MASK: mask_next = i_pwdata[STAT_W-1:0];
        default: if (lvl_hit(i_paddr)) lvl_next[lvl_i] = i_pwdata[SMP_W-1:0];
      endcase
    end
    // sticky status: a new event wins over a write-one clear
    stat_next = stat_reg;
    if (wr_acc && i_paddr == OFF_STATUS) stat_next = stat_reg & ~i_pwdata[STAT_W-1:0];
    stat_next[STAT_SETUP] = stat_next[STAT_SETUP] | sv;
    stat_next[STAT_HOLD] = stat_next[STAT_HOLD] | hv;
    stat_next[STAT_CMDERR] = stat_next[STAT_CMDERR] | (acc_ph & bad_src);
  end

  // read data is latched in the setup phase, valid through the access phase
  always_comb begin
    rd_next = rd_reg;
    if (setup_ph && !i_pwrite) begin
      rd_next = '0;
      case (i_paddr)
        OFF_CTRL: rd_next[CTRL_W-1:0] = ctrl_reg;
        OFF_CLK_SRC: rd_next[SRC_W-1:0] = csrc_reg;
        OFF_DATA_SRC: rd_next[SRC_W-1:0] = dsrc_reg;
        OFF_SETUP: rd_next[TIME_W-1:0] = setup_reg;
        OFF_HOLD: rd_next[TIME_W-1:0] = hold_reg;
        OFF_HTHR: rd_next[SMP_W-1:0] = hthr_reg;
        OFF_LTHR: rd_next[SMP_W-1:0] = lthr_reg;
        OFF_STATUS: rd_next[STAT_W-1:0] = stat_reg;
        OFF_MASK: rd_next[STAT_W-1:0] = mask_reg;
        default: if (lvl_hit(i_paddr)) begin
          rd_next[SMP_W-1:0] = lvl_reg[lvl_i];
          rd_next[LVL_SRC_LSB +: SRC_W] = SRC_W'(lvl_i) + SRC_CH1;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= '0;
      csrc_reg <= SRC_CH1;
      dsrc_reg <= SRC_CH2;
      setup_reg <= SETUP_RST;
      hold_reg <= HOLD_RST;
      hthr_reg <= HTHR_RST;
      lthr_reg <= LTHR_RST;
      stat_reg <= '0;
      mask_reg <= '0;
      rd_reg <= '0;
      for (int k = 0; k < NSRC; k++) lvl_reg[k] <= LVL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      csrc_reg <= csrc_next;
      dsrc_reg <= dsrc_next;
      setup_reg <= setup_next;
      hold_reg <= hold_next;
      hthr_reg <= hthr_next;
      lthr_reg <= lthr_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rd_reg <= rd_next;
      for (int k = 0; k < NSRC; k++) lvl_reg[k] <= lvl_next[k];
    end
  end

  assign o_prdata = rd_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = acc_ph & (~mapped | bad_src);
  assign o_irq = |(stat_reg & mask_reg);

  svht_mon_if mon ();

  // source routing into the comparators
  assign mon.clk_sample = smp_s2_reg[src_idx(csrc_reg)*SMP_W +: SMP_W];
  assign mon.clk_level = lvl_reg[src_idx(csrc_reg)];
  assign mon.data_sample = smp_s2_reg[src_idx(dsrc_reg)*SMP_W +: SMP_W];
  assign mon.hi_thr = hthr_reg;
  assign mon.lo_thr = lthr_reg;

  svht_level_cmp u_cmp (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .mon       (mon)
  );

  svht_checker u_chk (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .mon          (mon),
    .i_en         (ctrl_reg[CTRL_EN_BIT]),
    .i_edge       (svht_edge_t'(ctrl_reg[CTRL_EDGE_BIT])),
    .i_setup_cyc  (ns_to_cyc(setup_reg)),
    .i_hold_cyc   (ns_to_cyc(hold_reg)),
    .o_setup_viol (sv),
    .o_hold_viol  (hv),
    .o_trig       (trig)
  );

  assign o_setup_viol = sv;
  assign o_hold_viol = hv;
  assign o_trig = trig;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // events, readback and source refusal
  a_setup_sticky: assert property (
    sv |=> stat_reg[STAT_SETUP])
    else $error("setup event not recorded");
  a_setup_read: assert property (
    setup_ph && !i_pwrite && i_paddr == OFF_SETUP |=> o_prdata[TIME_W-1:0] == $past(setup_reg))
    else $error("setup readback wrong");
  a_src_range: assert property (
    wr_acc && i_paddr == OFF_CLK_SRC && !src_ok(i_pwdata[SRC_W-1:0])
      |=> $stable(csrc_reg) && stat_reg[STAT_CMDERR])
    else $error("bad clock source accepted");
  a_ext_block: assert property (
    !TWO_CH_MODEL |-> dsrc_reg != SRC_EXT && csrc_reg != SRC_EXT)
    else $error("external source on wide model");
  a_lvl_read: assert property (
    setup_ph && !i_pwrite && i_paddr == OFF_LVL_BASE
      |=> o_prdata[LVL_SRC_LSB +: SRC_W] == SRC_CH1)
    else $error("level readback source wrong");
  a_edge_read: assert property (
    setup_ph && !i_pwrite && i_paddr == OFF_CTRL
      |=> o_prdata[CTRL_EDGE_BIT] == $past(ctrl_reg[CTRL_EDGE_BIT]))
    else $error("edge readback wrong");
  a_csrc_read: assert property (
    setup_ph && !i_pwrite && i_paddr == OFF_CLK_SRC |=> o_prdata[SRC_W-1:0] == $past(csrc_reg))
    else $error("clock source readback wrong");
  a_dsrc_read: assert property (
    setup_ph && !i_pwrite && i_paddr == OFF_DATA_SRC |=> o_prdata[SRC_W-1:0] == $past(dsrc_reg))
    else $error("data source readback wrong");
  a_trig_single: assert property (
    (sv || hv) |-> trig)
    else $error("trigger missing for violation");
  a_trig_cause: assert property (
    trig |-> (sv || hv))
    else $error("trigger without violation");
  a_hold_sticky: assert property (
    hv |=> stat_reg[STAT_HOLD])
    else $error("hold event not recorded");
  a_idle_quiet: assert property (
    !ctrl_reg[CTRL_EN_BIT] |=> !sv && !hv)
    else $error("violation while disabled");

  // written values land one edge after the access phase
  a_setup_write: assert property (
    wr_acc && i_paddr == OFF_SETUP |=> setup_reg == $past(i_pwdata[TIME_W-1:0]))
    else $error("setup time write lost");
  a_csrc_write: assert property (
    wr_acc && i_paddr == OFF_CLK_SRC && !bad_src |=> csrc_reg == $past(i_pwdata[SRC_W-1:0]))
    else $error("clock source write lost");
  a_dsrc_write: assert property (
    wr_acc && i_paddr == OFF_DATA_SRC && !bad_src |=> dsrc_reg == $past(i_pwdata[SRC_W-1:0]))
    else $error("data source write lost");
  a_lvl_write: assert property (
    wr_acc && lvl_hit(i_paddr) |=> lvl_reg[$past(lvl_i)] == $past(i_pwdata[SMP_W-1:0]))
    else $error("clock level write lost");
  a_edge_write: assert property (
    wr_acc && i_paddr == OFF_CTRL
      |=> ctrl_reg[CTRL_EDGE_BIT] == $past(i_pwdata[CTRL_EDGE_BIT]))
    else $error("edge choice write lost");
  a_thr_write: assert property (
    wr_acc && i_paddr == OFF_HTHR |=> hthr_reg == $past(i_pwdata[SMP_W-1:0]))
    else $error("high threshold write lost");

  // status clearing, refusal and read data holding
  a_stat_clear: assert property (
    wr_acc && i_paddr == OFF_STATUS && i_pwdata[STAT_SETUP] && !sv |=> !stat_reg[STAT_SETUP])
    else $error("setup status not cleared");
  a_dsrc_range: assert property (
    wr_acc && i_paddr == OFF_DATA_SRC && !src_ok(i_pwdata[SRC_W-1:0])
      |=> $stable(dsrc_reg) && stat_reg[STAT_CMDERR])
    else $error("bad data source accepted");
  a_rd_stable: assert property (
    acc_ph |=> $stable(o_prdata))
    else $error("read data moved after access");
  a_irq_rise: assert property (
    $rose(o_irq)
      |-> $past(sv || hv || (acc_ph && bad_src) || (wr_acc && i_paddr == OFF_MASK)))
    else $error("interrupt rose without cause");

  c_setup_viol: cover property (sv);
  c_hold_viol: cover property (hv);
  c_cmd_err: cover property (acc_ph && bad_src);
  c_irq: cover property (o_irq);
  c_fall_viol: cover property (sv && ctrl_reg[CTRL_EDGE_BIT]);
endmodule
`default_nettype wire

// >>> testbench/svht_probe_model.sv
`timescale 1ns/1ns
`default_nettype none
module svht_probe_model
  import svht_pkg::*;
(
  input  wire logic                  i_sys_clk,  // system clock
  input  wire logic [SRC_W-1:0]      i_clk_src,  // channel carrying the clock
  input  wire logic [SRC_W-1:0]      i_dat_src,  // channel carrying the data
  input  wire logic [SMP_W-1:0]      i_clk_code, // clock waveform code
  input  wire logic [SMP_W-1:0]      i_dat_code, // data waveform code
  output logic      [NSRC*SMP_W-1:0] o_chan_smp  // all probe samples
);
  logic [SMP_W-1:0] noise_reg = 8'h00;
  // idle channels wander every cycle so a wrong route never looks quiet
  always @(posedge i_sys_clk) begin
    noise_reg <= noise_reg + 8'h37;
  end
  always_comb begin
    for (int k = 0; k < NSRC; k++) begin
      if (SRC_W'(k + 1) == i_clk_src) begin
        o_chan_smp[k*SMP_W +: SMP_W] = i_clk_code;
      end else if (SRC_W'(k + 1) == i_dat_src) begin
        o_chan_smp[k*SMP_W +: SMP_W] = i_dat_code;
      end else begin
        o_chan_smp[k*SMP_W +: SMP_W] = noise_reg ^ SMP_W'(k * 8'h11);
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/svht_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module svht_top_tb;
  import svht_pkg::*;
  localparam logic [7:0] LO = 8'h10;
  localparam logic [7:0] HI = 8'hF0;
  localparam logic [7:0] MID = 8'h80;
  logic                  i_sys_clk;
  logic                  i_rst_n;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           o_prdata;
  logic                  o_pready;
  logic                  o_pslverr;
  logic [NSRC*SMP_W-1:0] chan_smp;
  logic                  o_trig;
  logic                  o_setup_viol;
  logic                  o_hold_viol;
  logic                  o_irq;
  logic [SRC_W-1:0]      clk_src;
  logic [SRC_W-1:0]      dat_src;
  logic [SMP_W-1:0]      clk_code;
  logic [SMP_W-1:0]      dat_code;
  logic [31:0]           rdv;
  logic                  erv;
  logic                  fall;
  int                    err_count;
  int                    num_checks;
  int                    cyc;
  logic [7:0]  ra [9] = '{OFF_CTRL, OFF_CLK_SRC, OFF_DATA_SRC, OFF_SETUP, OFF_HOLD,
                          OFF_HTHR, OFF_LTHR, OFF_STATUS, OFF_MASK};
  logic [31:0] rv [9] = '{32'h0, 32'h1, 32'h2, 32'(SETUP_RST), 32'(HOLD_RST),
                          32'(HTHR_RST), 32'(LTHR_RST), 32'h0, 32'h0};
  svht_top dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_chan_smp(chan_smp), .o_trig(o_trig), .o_setup_viol(o_setup_viol),
    .o_hold_viol(o_hold_viol), .o_irq(o_irq));
  svht_probe_model probe_u (.i_sys_clk(i_sys_clk),
    .i_clk_src(clk_src), .i_dat_src(dat_src), .i_clk_code(clk_code),
    .i_dat_code(dat_code), .o_chan_smp(chan_smp));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      err_count++;
      $display("mismatch t=%0t run did not finish", $time);
      conclude();
    end
  end
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    chk_val({31'h0, g}, {31'h0, e}, m);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'b1);
    rdv = o_prdata;
    erv = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk_bit(erv, ee, "write error flag");
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_val(rdv, e, "read data");
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(negedge i_sys_clk);
    chk_bit(o_irq, e, "interrupt level");
  endtask
  // a band code breaks the data, which then settles lead cycles before the
  // active clock move; hchg flips it after
  task automatic edge_case(input logic [7:0] dat, input int lead, input int hchg,
                           input logic es, input logic eh);
    int ns, nh, nt;
    ns = 0;
    nh = 0;
    nt = 0;
    @(posedge i_sys_clk);
    clk_code <= fall ? 8'hE0 : 8'h20;
    dat_code <= MID;
    @(posedge i_sys_clk);
    dat_code <= dat;
    repeat (lead) @(posedge i_sys_clk);
    clk_code <= fall ? 8'h20 : 8'hE0;
    for (int i = 0; i < 30; i++) begin
      @(posedge i_sys_clk);
      if (i == hchg) dat_code <= dat ^ 8'hE0;
      @(negedge i_sys_clk);
      ns += (o_setup_viol === 1'b1);
      nh += (o_hold_viol === 1'b1);
      nt += (o_trig === 1'b1);
    end
    chk_val(32'(ns), {31'h0, es}, "setup pulses");
    chk_val(32'(nh), {31'h0, eh}, "hold pulses");
    chk_val(32'(nt), {31'h0, es | eh}, "trigger pulses");
  endtask
  initial begin
    logic [31:0] prev [2];
    logic [7:0]  lv;
    logic        ok;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    i_rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    clk_src = 3'h4;
    dat_src = 3'h1;
    clk_code = 8'h20;
    dat_code = HI;
    fall = 1'b0;
    prev = '{32'h1, 32'h2};
    void'($urandom(32'h7ae8));
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int r = 0; r < 9; r++) rdc(ra[r], rv[r]);
    for (int i = 0; i < 5; i++) rdc(8'(OFF_LVL_BASE + 4 * i), {21'h0, 3'(i + 1), 8'h80});
    apb(1'b0, 8'h24, 32'h0);
    chk_val(rdv, 32'h0, "unmapped read");
    chk_bit(erv, 1'b1, "unmapped error");
    wr(8'h3C, 32'hFFFF_FFFF, 1'b1);
    wr(OFF_MASK, 32'h7, 1'b0);
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 2; r++) begin
        ok = (c >= 1 && c <= 4);
        wr(r ? OFF_DATA_SRC : OFF_CLK_SRC, 32'(c), !ok);
        if (ok) prev[r] = 32'(c);
        rdc(r ? OFF_DATA_SRC : OFF_CLK_SRC, prev[r]);
      end
    end
    rdc(OFF_STATUS, 32'h4);
    chk_irq(1'b1);
    wr(OFF_STATUS, 32'h7, 1'b0);
    chk_irq(1'b0);
    wr(OFF_DATA_SRC, 32'h1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      lv = 8'($urandom_range(255));
      wr(8'(OFF_LVL_BASE + 4 * i), {24'h0, lv}, 1'b0);
      rdc(8'(OFF_LVL_BASE + 4 * i), {21'h0, 3'(i + 1), lv});
    end
    wr(8'(OFF_LVL_BASE + 12), 32'h80, 1'b0);
    pwdata <= 32'($urandom_range(90, 50));
    @(posedge i_sys_clk);
    wr(OFF_SETUP, pwdata, 1'b0);
    rdc(OFF_SETUP, pwdata);
    wr(OFF_HOLD, 32'h0, 1'b0);
    wr(OFF_CTRL, 32'h1, 1'b0);
    edge_case(LO, 2, -1, 1'b0, 1'b0);
    edge_case(LO, 2, -1, 1'b1, 1'b0);
    rdc(OFF_STATUS, 32'h1);
    chk_irq(1'b1);
    wr(OFF_MASK, 32'h6, 1'b0);
    chk_irq(1'b0);
    wr(OFF_STATUS, 32'h1, 1'b0);
    wr(OFF_MASK, 32'h7, 1'b0);
    edge_case(HI, 15, -1, 1'b0, 1'b0);
    edge_case(MID, 15, -1, 1'b1, 1'b0);
    pwdata <= 32'($urandom_range(90, 50));
    @(posedge i_sys_clk);
    wr(OFF_HOLD, pwdata, 1'b0);
    edge_case(LO, 15, 2, 1'b0, 1'b1);
    edge_case(HI, 15, -1, 1'b0, 1'b0);
    rdc(OFF_STATUS, 32'h3);
    wr(OFF_CTRL, 32'h0, 1'b0);
    wr(OFF_CTRL, 32'h3, 1'b0);
    rdc(OFF_CTRL, 32'h3);
    fall = 1'b1;
    edge_case(LO, 2, -1, 1'b0, 1'b0);
    edge_case(LO, 2, -1, 1'b1, 1'b0);
    wr(OFF_CTRL, 32'h0, 1'b0);
    fall = 1'b0;
    edge_case(LO, 2, -1, 1'b0, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
